// ### common/scsp_pkg.sv
// Operation
// - fuses 0011 select 128 kHz oscillator
// - 128k source: wake 6CK, reset 14CK+0/4/64ms
// - fuses 0000 select external clock pin
// - external: wake 6CK, reset 14CK+0/4.1/65ms
// - clock out fuse drives system clock out
// - clock output is the divided clock
// - timer pin clock only when select set
// - prescaler divides every source, all synchronous domains
// - division change is glitch free
// - new rate at end of current divided period
// - ripple counter on source, count unreadable
// - unlock write then select within four
// - factory trim loaded at reset
// - trim top bit picks frequency range
// - low seven trim bits tune within range
// - enable clears after four cycles or write
// - enable updates only with others zero
// - select code gives divide two power code
// - reset select from divide-by-eight fuse
package scsp_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFS_PRESCALE   = 8'h00;
	localparam logic [7:0] OFS_TRIM       = 8'h04;
	localparam logic [7:0] OFS_TIMER_STAT = 8'h08;
	localparam logic [7:0] OFS_STATUS     = 8'h0c;
	// prescale and timer status register fields
	localparam int PCE_BIT      = 7;
	localparam int TIMER_EXT_BIT = 6;
	// fuse codes
	localparam logic [3:0] SRC_EXTERNAL = 4'h0;
	localparam logic [3:0] SRC_OSC128   = 4'h3;
	// select codes
	localparam logic [3:0] SEL_DIV1     = 4'h0;
	localparam logic [3:0] SEL_DIV8     = 4'h3;
	localparam logic [3:0] SEL_MAX      = 4'h8;
	// wake and reset counts in source clock cycles, change window in bus cycles
	localparam logic [3:0] WAKE_CK      = 4'h6;
	localparam logic [3:0] RESET_CK     = 4'he;
	localparam logic [2:0] PCE_WINDOW   = 3'h4;
	// bus clock period and extra reset delays
	localparam int CLK_PERIOD_NS  = 8;
	localparam int OSC_DLY_SHORT_US = 4000;
	localparam int OSC_DLY_LONG_US  = 64000;
	localparam int EXT_DLY_SHORT_US = 4100;
	localparam int EXT_DLY_LONG_US  = 65000;
	localparam int OSC_DLY_SHORT_CYC = OSC_DLY_SHORT_US * 1000 / CLK_PERIOD_NS;
	localparam int OSC_DLY_LONG_CYC  = OSC_DLY_LONG_US * 1000 / CLK_PERIOD_NS;
	localparam int EXT_DLY_SHORT_CYC = EXT_DLY_SHORT_US * 1000 / CLK_PERIOD_NS;
	localparam int EXT_DLY_LONG_CYC  = EXT_DLY_LONG_US * 1000 / CLK_PERIOD_NS;
	// reset values
	localparam logic [31:0] RDATA_RST = 32'h0000_0000;
	// start-up sequencer states
	typedef enum logic [1:0] {ST_CAPTURE, ST_CK_WAIT, ST_MS_WAIT, ST_RUN} scsp_start_e;
endpackage

// ### logic/scsp_divider.sv
`timescale 1ns/10ps
`default_nettype none
module scsp_divider (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       src_tick,      // one-cycle pulse per source active edge
	input  wire logic       src_level,     // undivided source level
	input  wire logic [3:0] sel_req,       // requested select code
	input  wire logic       sel_init_load, // load sel_req directly at start-up
	output logic            sys_tick,      // one pulse per divided active edge
	output logic            sys_level,     // divided clock level
	output logic [3:0]      sel_active     // code now in force
);
	logic [7:0] cnt_reg;    // source-edge counter, not visible to software
	logic [7:0] last_cnt;   // terminal count of the active code
	logic       wrap;

	assign last_cnt = 8'((9'h001 << sel_active) - 9'h001);
	assign wrap     = src_tick && (cnt_reg == last_cnt);

	// counter advances only on source edges, so its state is never exposed
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_reg <= 8'h00;
		end else if (wrap || sel_init_load) begin
			cnt_reg <= 8'h00;
		end else if (src_tick) begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end

	// new code only taken at a period boundary: the old period finishes, then
	// the new one runs whole, so no short pulse and no faster intermediate rate
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_active <= scsp_pkg::SEL_DIV1;
		end else if (sel_init_load) begin
			sel_active <= sel_req;
		end else if (wrap && sel_req <= scsp_pkg::SEL_MAX) begin
			sel_active <= sel_req;
		end
	end

	// divided edge pulse, which every synchronous domain uses
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sys_tick <= 1'b0;
		end else begin
			sys_tick <= wrap;
		end
	end

	// level: high for the first half of each divided period
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sys_level <= 1'b0;
		end else if (sel_active == scsp_pkg::SEL_DIV1) begin
			sys_level <= src_level;
		end else begin
			sys_level <= (cnt_reg < (8'h01 << (sel_active - 4'h1)));
		end
	end
endmodule
`default_nettype wire

// ### logic/scsp_top.sv
`timescale 1ns/10ps
`default_nettype none
module scsp_top #(
	parameter int OSC_DLY_SHORT = scsp_pkg::OSC_DLY_SHORT_CYC, // 4 ms in bus cycles
	parameter int OSC_DLY_LONG  = scsp_pkg::OSC_DLY_LONG_CYC,  // 64 ms in bus cycles
	parameter int EXT_DLY_SHORT = scsp_pkg::EXT_DLY_SHORT_CYC, // 4.1 ms in bus cycles
	parameter int EXT_DLY_LONG  = scsp_pkg::EXT_DLY_LONG_CYC   // 65 ms in bus cycles
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	// static configuration fuses
	input  wire logic [3:0]  clock_source_select_fuses,
	input  wire logic [1:0]  startup_time_fuses,
	input  wire logic        clock_out_fuse,
	input  wire logic        div8_startup_fuse,
	input  wire logic [7:0]  factory_trim,
	// clock sources
	input  wire logic        ext_clock_input_pin,
	input  wire logic        osc128_level,
	input  wire logic        timer_osc_input_pin,
	input  wire logic        timer_crystal_clk,
	// sleep wake request
	input  wire logic        wake_req,
	// normal function of the shared clock out pin
	input  wire logic        gpio_out,
	input  wire logic        gpio_oe_n,
	// outputs
	output logic             clock_out_pin_o,
	output logic             clock_out_pin_oe_n,
	output logic             sys_clk_tick,
	output logic             core_ready,
	output logic             wake_done,
	output logic             timer_clk,
	output logic             trim_range_bit,
	output logic [6:0]       trim_fine_bits
);
	// captured configuration
	logic [3:0]  src_fuse_reg;      // source code held after reset
	logic [1:0]  sut_fuse_reg;      // start-up code held after reset
	logic        cko_fuse_reg;      // clock out enable held after reset
	// source edge detection
	logic        src_level;
	logic        src_prev_reg;
	logic        src_tick;
	// registers
	logic [3:0]  prescale_select_reg;
	logic        pce_reg;
	logic [2:0]  pce_cnt_reg;
	logic [7:0]  trim_reg;
	logic        timer_ext_reg;
	// bus pipeline
	logic        wr_pend_reg;
	logic        rd_pend_reg;
	logic [7:0]  addr_reg;
	logic        addr_phase;
	logic        wr_prescale;
	// start-up
	scsp_pkg::scsp_start_e st_reg;
	logic [3:0]  ck_cnt_reg;
	logic [31:0] ms_cnt_reg;
	logic [31:0] ms_target;
	logic        init_load;
	logic [3:0]  wake_cnt_reg;
	logic        wake_busy_reg;
	// divider outputs
	logic        div_tick;
	logic        div_level;
	logic [3:0]  sel_active;
	logic [3:0]  sel_req_mux;       // fuse code at capture, register afterwards

	// fuses are static; caught once, the first edge after reset release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_fuse_reg <= 4'h0;
			sut_fuse_reg <= 2'h0;
			cko_fuse_reg <= 1'b0;
		end else if (st_reg == scsp_pkg::ST_CAPTURE) begin
			src_fuse_reg <= clock_source_select_fuses;
			sut_fuse_reg <= startup_time_fuses;
			cko_fuse_reg <= clock_out_fuse;
		end
	end

	// source mux; codes other than the two handled give no clock at all
	always_comb begin
		case (src_fuse_reg)
			scsp_pkg::SRC_OSC128:   src_level = osc128_level;
			scsp_pkg::SRC_EXTERNAL: src_level = ext_clock_input_pin;
			default:                src_level = 1'b0;
		endcase
	end

	// rising edges of the chosen source become one-cycle ticks; the pins are
	// synchronous, and the source must stay well below half the bus rate
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			src_prev_reg <= 1'b0;
		end else begin
			src_prev_reg <= src_level;
		end
	end
	assign src_tick = src_level && !src_prev_reg;

	// extra reset delay by start-up code; reserved code takes the longest
	always_comb begin
		ms_target = 32'h0000_0000;
		case (sut_fuse_reg)
			2'b00:   ms_target = 32'h0000_0000;
			2'b01:   ms_target = (src_fuse_reg == scsp_pkg::SRC_OSC128) ?
				32'(OSC_DLY_SHORT) : 32'(EXT_DLY_SHORT);
			default: ms_target = (src_fuse_reg == scsp_pkg::SRC_OSC128) ?
				32'(OSC_DLY_LONG) : 32'(EXT_DLY_LONG);
		endcase
	end

	// start-up sequencer: capture, 14 source edges, then the timed delay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_reg     <= scsp_pkg::ST_CAPTURE;
			ck_cnt_reg <= 4'h0;
			ms_cnt_reg <= 32'h0000_0000;
		end else begin
			case (st_reg)
				scsp_pkg::ST_CAPTURE: begin
					st_reg <= scsp_pkg::ST_CK_WAIT;
				end
				scsp_pkg::ST_CK_WAIT: begin
					if (src_tick) begin
						ck_cnt_reg <= ck_cnt_reg + 4'h1;
						if (ck_cnt_reg == scsp_pkg::RESET_CK - 4'h1) begin
							st_reg <= scsp_pkg::ST_MS_WAIT;
						end
					end
				end
				scsp_pkg::ST_MS_WAIT: begin
					if (ms_cnt_reg >= ms_target) begin
						st_reg <= scsp_pkg::ST_RUN;
					end else begin
						ms_cnt_reg <= ms_cnt_reg + 32'h0000_0001;
					end
				end
				scsp_pkg::ST_RUN: begin
					st_reg <= scsp_pkg::ST_RUN;
				end
				default: begin
					st_reg <= scsp_pkg::ST_CAPTURE;
				end
			endcase
		end
	end
	assign init_load = (st_reg == scsp_pkg::ST_CAPTURE);

	// the register only holds the fuse code one edge after capture, so the
	// divider takes the fuse code itself; otherwise it would start at full rate
	assign sel_req_mux = init_load ?
		(div8_startup_fuse ? scsp_pkg::SEL_DIV8 : scsp_pkg::SEL_DIV1) : prescale_select_reg;

	// core released once the sequencer reaches run
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			core_ready <= 1'b0;
		end else begin
			core_ready <= (st_reg == scsp_pkg::ST_RUN);
		end
	end

	// wake-up: six source edges after a wake request
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wake_busy_reg <= 1'b0;
			wake_cnt_reg  <= 4'h0;
			wake_done     <= 1'b0;
		end else begin
			wake_done <= 1'b0;
			if (!wake_busy_reg) begin
				wake_busy_reg <= wake_req;
				wake_cnt_reg  <= 4'h0;
			end else if (src_tick) begin
				wake_cnt_reg <= wake_cnt_reg + 4'h1;
				if (wake_cnt_reg == scsp_pkg::WAKE_CK - 4'h1) begin
					wake_busy_reg <= 1'b0;
					wake_done     <= 1'b1;
				end
			end
		end
	end

	// ahb-lite: writes have no wait state, reads take one wait state so the
	// read mux sees any write completed in the cycle before
	assign addr_phase = hsel && htrans[1] && hready;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_reg <= 1'b0;
			rd_pend_reg <= 1'b0;
			addr_reg    <= 8'h00;
			hreadyout   <= 1'b1;
			hresp       <= 1'b0;
		end else begin
			wr_pend_reg <= addr_phase && hwrite && (hsize == 3'b010);
			rd_pend_reg <= addr_phase && !hwrite;
			hreadyout   <= !(addr_phase && !hwrite);
			hresp       <= 1'b0;
			if (addr_phase) begin
				addr_reg <= haddr[7:0];
			end
		end
	end

	// read data captured in the wait state; unmapped reads return zero
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= scsp_pkg::RDATA_RST;
		end else if (rd_pend_reg) begin
			case (addr_reg)
				scsp_pkg::OFS_PRESCALE:   hrdata <= {24'h00_0000, pce_reg, 3'h0, prescale_select_reg};
				scsp_pkg::OFS_TRIM:       hrdata <= {24'h00_0000, trim_reg};
				scsp_pkg::OFS_TIMER_STAT: hrdata <= {25'h000_0000, timer_ext_reg, 6'h00};
				scsp_pkg::OFS_STATUS:     hrdata <= {20'h0_0000, sel_active, src_fuse_reg,
					1'b0, st_reg == scsp_pkg::ST_RUN, sut_fuse_reg};
				default:                  hrdata <= scsp_pkg::RDATA_RST;
			endcase
		end
	end

	assign wr_prescale = wr_pend_reg && (addr_reg == scsp_pkg::OFS_PRESCALE);

	// change-enable: armed only by a write with every other bit zero; its
	// window is not extended by a rewrite, and a select write closes it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pce_reg     <= 1'b0;
			pce_cnt_reg <= 3'h0;
		end else if (wr_prescale && pce_reg && !hwdata[scsp_pkg::PCE_BIT]) begin
			pce_reg <= 1'b0;
		end else if (wr_prescale && !pce_reg && hwdata[7:0] == 8'h80) begin
			pce_reg     <= 1'b1;
			pce_cnt_reg <= scsp_pkg::PCE_WINDOW - 3'h1;
		end else if (pce_reg) begin
			if (pce_cnt_reg == 3'h0) begin
				pce_reg <= 1'b0;
			end else begin
				pce_cnt_reg <= pce_cnt_reg - 3'h1;
			end
		end
	end

	// select bits take a write only inside an open window
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prescale_select_reg <= scsp_pkg::SEL_DIV1;
		end else if (init_load) begin
			prescale_select_reg <= div8_startup_fuse ? scsp_pkg::SEL_DIV8 : scsp_pkg::SEL_DIV1;
		end else if (wr_prescale && pce_reg && !hwdata[scsp_pkg::PCE_BIT]) begin
			prescale_select_reg <= hwdata[3:0];
		end
	end

	// trim: factory value loaded at release, then free for software
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trim_reg <= 8'h00;
		end else if (init_load) begin
			trim_reg <= factory_trim;
		end else if (wr_pend_reg && addr_reg == scsp_pkg::OFS_TRIM) begin
			trim_reg <= hwdata[7:0];
		end
	end

	// trim fields go straight to the oscillator's range and fine controls
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			trim_range_bit <= 1'b0;
			trim_fine_bits <= 7'h00;
		end else begin
			trim_range_bit <= trim_reg[7];
			trim_fine_bits <= trim_reg[6:0];
		end
	end

	// timer external clock select and the timer clock mux
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_ext_reg <= 1'b0;
		end else if (wr_pend_reg && addr_reg == scsp_pkg::OFS_TIMER_STAT) begin
			timer_ext_reg <= hwdata[scsp_pkg::TIMER_EXT_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			timer_clk <= 1'b0;
		end else begin
			timer_clk <= timer_ext_reg ? timer_osc_input_pin : timer_crystal_clk;
		end
	end

	// prescaler; rate change lands only on a divided period boundary
	scsp_divider u_div (
		.hclk          (hclk),
		.hresetn       (hresetn),
		.src_tick      (src_tick),
		.src_level     (src_level),
		.sel_req       (sel_req_mux),
		.sel_init_load (init_load),
		.sys_tick      (div_tick),
		.sys_level     (div_level),
		.sel_active    (sel_active)
	);

	// divided edge pulse for the cpu, i/o, converter and flash domains
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sys_clk_tick <= 1'b0;
		end else begin
			sys_clk_tick <= div_tick;
		end
	end

	// clock out overrides the pin's normal function; it runs during the
	// start-up delay too, since the fuse is caught right at release
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			clock_out_pin_o    <= 1'b0;
			clock_out_pin_oe_n <= 1'b1;
		end else if (cko_fuse_reg) begin
			clock_out_pin_o    <= div_level;
			clock_out_pin_oe_n <= 1'b0;
		end else begin
			clock_out_pin_o    <= gpio_out;
			clock_out_pin_oe_n <= gpio_oe_n;
		end
	end
endmodule
`default_nettype wire

// ### tb/scsp_ext_clock.sv
`timescale 1ns/10ps
`default_nettype none
// external clock source on the clock input pin
module scsp_ext_clock #(
	parameter int HALF = 3 // half period in bus cycles
) (
	input  wire logic hclk,
	output logic      clk_o
);
	int cnt = 0; // cycles into this half period
	initial clk_o = 1'b0;
	// fixed rate: zero drift from one cycle to the next
	always @(posedge hclk) begin
		if (cnt == HALF - 1) begin
			cnt <= 0;
			clk_o <= ~clk_o;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule
`default_nettype wire

// ### tb/scsp_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module scsp_assertions (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        clock_out_fuse,
	input wire logic        clock_out_pin_oe_n,
	input wire logic        sys_clk_tick,
	input wire logic        core_ready,
	input wire logic        wake_done,
	input wire logic        trim_range_bit,
	input wire logic [6:0]  trim_fine_bits
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	logic [7:0] cyc_cnt; // cycles since release, saturating
	// counts up from reset so start-up checks know the age
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cyc_cnt <= 8'h00;
		end else if (cyc_cnt != 8'hff) begin
			cyc_cnt <= cyc_cnt + 8'h01;
		end
	end
	sequence s_rd_addr;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence s_wr_addr;
		hsel && htrans[1] && hready && hwrite && hsize == 3'h2;
	endsequence
	sequence s_rd_data;
		!hreadyout ##1 hreadyout;
	endsequence
	chk_read_wait: assert property (s_rd_addr |=> s_rd_data)
		else $error("read data phase not one wait");
	chk_write_ready: assert property (s_wr_addr |=> hreadyout)
		else $error("write data phase stalled");
	chk_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	chk_rdata_hold: assert property (!$stable(hrdata) |-> !$past(hreadyout))
		else $error("read data moved outside a read");
	chk_trim_write: assert property (
		s_wr_addr ##0 haddr[7:0] == 8'h04 |=> ##2 {trim_range_bit, trim_fine_bits} == $past(hwdata[7:0], 2))
		else $error("trim outputs not the written byte");
	chk_clock_out: assert property (cyc_cnt >= 8'h02 && clock_out_fuse |-> !clock_out_pin_oe_n)
		else $error("clock out pin not driven");
	chk_tick_single: assert property (sys_clk_tick |=> !sys_clk_tick)
		else $error("divided tick glitched");
	chk_wake_pulse: assert property (wake_done |=> !wake_done)
		else $error("wake done longer than a pulse");
	chk_ready_hold: assert property (core_ready |=> core_ready)
		else $error("core ready dropped");
	chk_ready_early: assert property ($rose(core_ready) |-> cyc_cnt >= 8'h1c)
		else $error("core ready before start-up count");
endmodule
bind scsp_top scsp_assertions chk_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
	.hready, .hreadyout, .hresp, .hrdata, .clock_out_fuse, .clock_out_pin_oe_n, .sys_clk_tick,
	.core_ready, .wake_done, .trim_range_bit, .trim_fine_bits);
`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
	logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic        hreadyout, hresp, ext_clk, pin_o, pin_oe_n, tick, core_ready, wake_done, timer_clk, t_range;
	logic [31:0] hrdata;
	logic [6:0]  t_fine;
	logic        osc128;
	logic        tosc = 1'b0, txtal = 1'b0, wake_req = 1'b0; // timer source levels and wake request
	logic [3:0]  src_fuses = 4'h0;  // external source
	logic [1:0]  sut_fuses = 2'h0;  // shortest start-up
	logic        cko_fuse = 1'b1, div8_fuse = 1'b1, gpio_out = 1'b0, gpio_oe_n = 1'b1;
	logic [7:0]  ftrim = 8'ha5;     // factory trim byte
	int          fail_count = 0, compares = 0;
	always #4 hclk = ~hclk;
	// slow internal source, kept below half the bus rate
	scsp_ext_clock #(.HALF(2)) osc_u (.hclk(hclk), .clk_o(osc128));
	scsp_ext_clock #(.HALF(3)) ext_u (.hclk(hclk), .clk_o(ext_clk));
	// short ms delays keep the run brief
	scsp_top #(.OSC_DLY_SHORT(20), .OSC_DLY_LONG(20), .EXT_DLY_SHORT(20), .EXT_DLY_LONG(20)) dut_u (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .clock_source_select_fuses(src_fuses), .startup_time_fuses(sut_fuses),
		.clock_out_fuse(cko_fuse), .div8_startup_fuse(div8_fuse), .factory_trim(ftrim),
		.ext_clock_input_pin(ext_clk), .osc128_level(osc128), .timer_osc_input_pin(tosc),
		.timer_crystal_clk(txtal), .wake_req(wake_req), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n),
		.clock_out_pin_o(pin_o), .clock_out_pin_oe_n(pin_oe_n), .sys_clk_tick(tick),
		.core_ready(core_ready), .wake_done(wake_done), .timer_clk(timer_clk),
		.trim_range_bit(t_range), .trim_fine_bits(t_fine));
	task automatic stop_test;
		if (fail_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic ck(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// address phase held until ready is seen at an edge, then the data phase
	// likewise; ready and read data are the values standing at that edge
	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] wd, output logic [31:0] d);
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		hsel <= 1'b1;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		d = hrdata;
	endtask
	task automatic bw(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] x;
		bus(a, 1'b1, wd, x);
	endtask
	task automatic tick_wait;
		@(negedge hclk);
		while (tick !== 1'b1) @(negedge hclk);
	endtask
	// divided period in bus cycles, and clock out rises over four periods
	task automatic meas(input int p, input int e);
		int n;
		int r;
		logic q;
		repeat (2) tick_wait;
		n = 0;
		do begin
			@(negedge hclk);
			n++;
		end while (tick !== 1'b1);
		ck(32'(n), 32'(p));
		q = pin_o;
		r = 0;
		repeat (4 * p) begin
			@(negedge hclk);
			if (pin_o === 1'b1 && q === 1'b0) r++;
			q = pin_o;
		end
		ck(32'(r), 32'(e));
		@(posedge hclk);
	endtask
	task automatic t_reset;
		logic [31:0] d;
		ck(32'(core_ready), 32'h0);
		bus(8'h04, 1'b0, 32'h0, d);
		ck(d, 32'h0000_00a5);
		ck(32'({t_range, t_fine}), 32'ha5);
		bus(8'h0c, 1'b0, 32'h0, d);
		ck(32'(d[11:8]), 32'(scsp_pkg::SEL_DIV8));
		ck(32'(d[7:4]), 32'(scsp_pkg::SRC_EXTERNAL));
		ck(32'(pin_oe_n), 32'h0);
		bus(8'h10, 1'b0, 32'h0, d);
		ck(d, 32'h0000_0000);
	endtask
	task automatic t_start;
		int n;
		n = 0;
		while (core_ready !== 1'b1 && n < 400) begin
			@(negedge hclk);
			n++;
		end
		ck(32'(core_ready), 32'h1);
		@(posedge hclk);
		wake_req <= 1'b1;
		@(posedge hclk);
		wake_req <= 1'b0;
		n = 0;
		while (wake_done !== 1'b1 && n < 200) begin
			@(negedge hclk);
			n++;
		end
		ck(32'(n >= 30 && n <= 60), 32'h1);
		@(posedge hclk);
	endtask
	// a dirty unlock, and a select written after the window closed
	task automatic t_refuse;
		logic [31:0] d;
		bw(8'h00, 32'h0000_0081);
		bw(8'h00, 32'h0000_0005);
		bus(8'h0c, 1'b0, 32'h0, d);
		ck(32'(d[11:8]), 32'h3);
		bw(8'h00, 32'h0000_0080);
		bus(8'h00, 1'b0, 32'h0, d);
		ck(32'(d[7]), 32'h1);
		repeat (4) @(posedge hclk);
		bus(8'h00, 1'b0, 32'h0, d);
		ck(32'(d[7]), 32'h0);
		bw(8'h00, 32'h0000_0005);
		bus(8'h0c, 1'b0, 32'h0, d);
		ck(32'(d[11:8]), 32'h3);
	endtask
	// no memory writes run here, so any trim value is safe
	task automatic t_trim;
		logic [31:0] d;
		bw(8'h04, 32'h0000_007f);
		repeat (2) @(negedge hclk);
		ck(32'({t_range, t_fine}), 32'h7f);
		@(posedge hclk);
		bw(8'h04, 32'h0000_0080);
		repeat (2) @(negedge hclk);
		ck(32'({t_range, t_fine}), 32'h80);
		@(posedge hclk);
		hsize <= 3'h0;
		bw(8'h04, 32'h0000_0011);
		hsize <= 3'h2;
		bus(8'h04, 1'b0, 32'h0, d);
		ck(d, 32'h0000_0080);
	endtask
	task automatic t_timer;
		tosc <= 1'b1;
		bw(8'h08, 32'h0000_0040);
		repeat (3) @(negedge hclk);
		ck(32'(timer_clk), 32'h1);
		@(posedge hclk);
		bw(8'h08, 32'h0000_0000);
		repeat (3) @(negedge hclk);
		ck(32'(timer_clk), 32'h0);
		@(posedge hclk);
	endtask
	// codes 0 to 9, reserved 9 keeps the last factor; no interrupts can split the pair
	task automatic t_div;
		logic [31:0] d;
		for (int k = 0; k <= 9; k++) begin
			bw(8'h00, 32'h0000_0080);
			bw(8'h00, 32'(k));
			bus(8'h00, 1'b0, 32'h0, d);
			ck(32'(d[3:0]), 32'(k));
			meas(6 << (k > 8 ? 8 : k), 4);
			bus(8'h0c, 1'b0, 32'h0, d);
			ck(32'(d[11:8]), 32'(k > 8 ? 8 : k));
		end
	endtask
	// second reset on the slow internal source, clock out fuse off, 01 start-up
	task automatic t_osc;
		logic [31:0] d;
		int n;
		hresetn <= 1'b0;
		src_fuses <= scsp_pkg::SRC_OSC128;
		sut_fuses <= 2'h1;
		cko_fuse <= 1'b0;
		div8_fuse <= 1'b0;
		ftrim <= 8'h3c;
		gpio_out <= 1'b1;
		gpio_oe_n <= 1'b0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		n = 0;
		while (core_ready !== 1'b1 && n < 300) begin
			@(posedge hclk);
			n++;
		end
		ck(32'(n >= 14 * 4 + 20 && n <= 14 * 4 + 40), 32'h1);
		bus(8'h04, 1'b0, 32'h0, d);
		ck(d, 32'h0000_003c);
		bus(8'h0c, 1'b0, 32'h0, d);
		ck(32'(d[11:0]), 32'({scsp_pkg::SEL_DIV1, scsp_pkg::SRC_OSC128, 1'b0, 1'b1, 2'b01}));
		meas(4, 0);
		ck(32'({pin_o, pin_oe_n}), 32'h2);
	endtask
	initial begin
		#640000;
		fail_count++;
		stop_test;
	end
	initial begin
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset;
		t_start;
		t_refuse;
		t_trim;
		t_timer;
		t_div;
		t_osc;
		stop_test;
	end
endmodule
`default_nettype wire
